// ---- common/pnv_pkg.sv ----
package pnv_pkg;

  // ****************************************
  // Command bytes
  // ****************************************
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  // ****************************************
  // Load actions on the load pulse pin
  // ****************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;

  // ****************************************
  // Memory geometry
  // ****************************************
  localparam int FLASH_ADDR_W = 12;
  localparam int FLASH_PAGE_W = 6;
  localparam int FLASH_WORDS = 4096;
  localparam int FLASH_PAGE_WORDS = 64;
  localparam int EE_ADDR_W = 9;
  localparam int EE_PAGE_W = 2;
  localparam int EE_BYTES = 512;
  localparam int EE_PAGE_BYTES = 4;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] ERASED_BYTE = 8'hFF;
  localparam logic [7:0] FUSE_LOW_RST = 8'hFF;
  localparam logic [7:0] FUSE_HIGH_RST = 8'hFF;
  localparam logic [7:0] FUSE_EXT_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int T_WR_FLASH_NS = 4500000;
  localparam int T_WR_EE_NS = 4000000;
  localparam int T_ERASE_NS = 4000000;
  localparam int T_WR_FUSE_NS = 4500000;
  localparam int T_PULSE_NS = 250;
  localparam int WR_FLASH_CYC = (T_WR_FLASH_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_EE_CYC = (T_WR_EE_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC = (T_ERASE_NS * CLK_MHZ + 999) / 1000;
  localparam int WR_FUSE_CYC = (T_WR_FUSE_NS * CLK_MHZ + 999) / 1000;
  localparam int PULSE_CYC = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 21;

  // ****************************************
  // Programmer register map
  // ****************************************
  localparam logic [7:0] REG_PINS = 8'h00;
  localparam logic [7:0] REG_DOUT = 8'h04;
  localparam logic [7:0] REG_STROBE = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_DIN = 8'h10;
  localparam logic [4:0] PINS_RST = 5'h10;
  localparam int PIN_ACT_LO = 0;
  localparam int PIN_ACT_HI = 1;
  localparam int PIN_BS1 = 2;
  localparam int PIN_BS2 = 3;
  localparam int PIN_RD_N = 4;
  localparam int STB_LOAD = 0;
  localparam int STB_LATCH = 1;
  localparam int STB_WRITE = 2;
  localparam int STS_DONE = 0;
  localparam int STS_PULSE = 1;

endpackage

// ---- common/pnv_link_if.sv ----
`timescale 1ns/1ps
interface pnv_link_if;
  logic action_sel_hi;
  logic action_sel_lo;
  logic byte_select_first;
  logic byte_select_second;
  logic page_latch_strobe;
  logic load_pulse_pin;
  logic write_strobe_n;
  logic read_enable_n;
  logic done_flag;
  logic [7:0] host_dat;
  logic host_dat_oe_n;
  logic [7:0] dev_dat;
  logic dev_dat_oe_n;
  logic [7:0] data_bus;

  // Resolved bus level; an undriven bus floats high.
  assign data_bus = !dev_dat_oe_n ? dev_dat : (!host_dat_oe_n ? host_dat : 8'hFF);

  modport device (
    input action_sel_hi, action_sel_lo, byte_select_first, byte_select_second,
    input page_latch_strobe, load_pulse_pin, write_strobe_n, read_enable_n, data_bus,
    output done_flag, dev_dat, dev_dat_oe_n
  );

  modport host (
    output action_sel_hi, action_sel_lo, byte_select_first, byte_select_second,
    output page_latch_strobe, load_pulse_pin, write_strobe_n, read_enable_n,
    output host_dat, host_dat_oe_n,
    input done_flag, data_bus
  );
endinterface

// ---- rtl/pnv_device.sv ----
// Functional notes
// - Latch pulse stores data word into page buffer; the code stores a flash word only with first byte select high.
// - Low address word in page, high bits page.
// - Action 00 with byte select high loads address high.
// - Write strobe programs flash page, done flag low.
// - Command zero is no-op, clears page session.
// - Programmer loads words, latches, then writes page.
// - EEPROM write command buffers latched bytes.
// - Byte select low write strobe programs EEPROM page.
// - Flash read drives low or high byte.
// - EEPROM read drives addressed byte.
// - Fuse write, selects 00, writes low fuses.
// - Fuse write, select first only, high fuses.
// - Fuse write, select second only, extended fuses.
// - Lock write programs bits loaded as zero.
// - Both lock bits programmed refuses lock writes.
// - Only chip erase clears lock bits.
// - Fuse read selects fuse byte or locks.
// - Signature read drives byte for address 0..2.
// - Address zero, select high reads calibration.
// - Load action codes: address, data, command, none.
// - Bus driven only while read enable low.
// - First byte select chooses data low or high.
// - Command and address held until replaced.
//
// Local design decisions: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module pnv_device #(
  parameter int unsigned WR_FLASH_CYC = pnv_pkg::WR_FLASH_CYC, // Flash page write time
  parameter int unsigned WR_EE_CYC = pnv_pkg::WR_EE_CYC, // EEPROM page write time
  parameter int unsigned ERASE_CYC = pnv_pkg::ERASE_CYC, // Chip erase time
  parameter int unsigned WR_FUSE_CYC = pnv_pkg::WR_FUSE_CYC, // Fuse and lock write time
  parameter logic [7:0] SIG_0 = 8'h5A, // Signature byte 0, arbitrary value
  parameter logic [7:0] SIG_1 = 8'h3C, // Signature byte 1, arbitrary value
  parameter logic [7:0] SIG_2 = 8'h21, // Signature byte 2, arbitrary value
  parameter logic [7:0] CAL_BYTE = 8'h80 // Oscillator calibration byte, arbitrary value
) (
  input wire logic SYS_CLK_I, // System clock
  input wire logic RST_N_I, // Asynchronous reset, active low
  pnv_link_if.device LINK, // Programming pins
  output logic [7:0] FUSE_LOW_O, // Low fuse byte
  output logic [7:0] FUSE_HIGH_O, // High fuse byte
  output logic [7:0] FUSE_EXT_O, // Extended fuse byte
  output logic [7:0] LOCK_O // Lock byte
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic {ST_IDLE, ST_BUSY} pnv_state_e;

  pnv_state_e state_reg;
  logic [pnv_pkg::TMR_W-1:0] tmr_reg;
  logic done_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_lo_reg;
  logic [7:0] addr_hi_reg;
  logic [7:0] data_lo_reg;
  logic [7:0] data_hi_reg;
  logic [7:0] fuse_low_reg;
  logic [7:0] fuse_high_reg;
  logic [7:0] fuse_ext_reg;
  logic [7:0] lock_reg;
  logic [pnv_pkg::EE_PAGE_BYTES-1:0] ee_mask_reg;
  logic [7:0] dout_reg;
  logic load_prev_reg;
  logic latch_prev_reg;
  logic wr_prev_reg;

  logic [15:0] flash_mem [pnv_pkg::FLASH_WORDS];
  logic [15:0] flash_buf [pnv_pkg::FLASH_PAGE_WORDS];
  logic [7:0] ee_mem [pnv_pkg::EE_BYTES];
  logic [7:0] ee_buf [pnv_pkg::EE_PAGE_BYTES];

  function automatic logic [pnv_pkg::TMR_W-1:0] cyc_load(input int unsigned cyc);
    cyc_load = pnv_pkg::TMR_W'(cyc - 1);
  endfunction

  // ****************************************
  // Pin decode
  // ****************************************
  wire logic bs1 = LINK.byte_select_first;
  wire logic bs2 = LINK.byte_select_second;
  wire logic [1:0] act = {LINK.action_sel_hi, LINK.action_sel_lo};
  wire logic load_rise = LINK.load_pulse_pin & ~load_prev_reg;
  wire logic latch_rise = LINK.page_latch_strobe & ~latch_prev_reg;
  wire logic wr_fall = wr_prev_reg & ~LINK.write_strobe_n;
  wire logic [7:0] bus = LINK.data_bus;
  wire logic load_nop = load_rise & (act == pnv_pkg::ACT_CMD) & (bus == pnv_pkg::CMD_NOP);

  wire logic is_flash = cmd_reg == pnv_pkg::CMD_WR_FLASH;
  wire logic is_ee = cmd_reg == pnv_pkg::CMD_WR_EE;
  wire logic is_fuse = cmd_reg == pnv_pkg::CMD_WR_FUSE;
  wire logic is_lock = cmd_reg == pnv_pkg::CMD_WR_LOCK;
  wire logic is_erase = cmd_reg == pnv_pkg::CMD_ERASE;
  wire logic lock_mode3 = lock_reg[1:0] == 2'h0;
  wire logic go = wr_fall & done_reg & (state_reg == ST_IDLE);
  wire logic go_flash = go & is_flash;
  wire logic go_ee = go & is_ee & ~bs1;
  wire logic go_fl = go & is_fuse & ~bs1 & ~bs2;
  wire logic go_fh = go & is_fuse & bs1 & ~bs2;
  wire logic go_fe = go & is_fuse & ~bs1 & bs2;
  wire logic go_lock = go & is_lock & ~lock_mode3;
  wire logic go_erase = go & is_erase;
  wire logic go_any = go_flash | go_ee | go_fl | go_fh | go_fe | go_lock | go_erase;
  wire logic [pnv_pkg::TMR_W-1:0] tmr_start = go_flash ? cyc_load(WR_FLASH_CYC) :
    go_ee ? cyc_load(WR_EE_CYC) : go_erase ? cyc_load(ERASE_CYC) : cyc_load(WR_FUSE_CYC);

  // ****************************************
  // Addressing
  // ****************************************
  wire logic [pnv_pkg::FLASH_ADDR_W-1:0] flash_addr =
    {addr_hi_reg[pnv_pkg::FLASH_ADDR_W-9:0], addr_lo_reg};
  wire logic [pnv_pkg::EE_ADDR_W-1:0] ee_addr =
    {addr_hi_reg[pnv_pkg::EE_ADDR_W-9:0], addr_lo_reg};
  wire logic [pnv_pkg::FLASH_ADDR_W-pnv_pkg::FLASH_PAGE_W-1:0] flash_page =
    flash_addr[pnv_pkg::FLASH_ADDR_W-1:pnv_pkg::FLASH_PAGE_W];
  wire logic [pnv_pkg::EE_ADDR_W-pnv_pkg::EE_PAGE_W-1:0] ee_page =
    ee_addr[pnv_pkg::EE_ADDR_W-1:pnv_pkg::EE_PAGE_W];
  wire logic [pnv_pkg::FLASH_PAGE_W-1:0] flash_word = addr_lo_reg[pnv_pkg::FLASH_PAGE_W-1:0];
  wire logic [pnv_pkg::EE_PAGE_W-1:0] ee_word = addr_lo_reg[pnv_pkg::EE_PAGE_W-1:0];

  // ****************************************
  // Read selection
  // ****************************************
  wire logic [15:0] flash_rd = flash_mem[flash_addr];
  wire logic [7:0] sig_rd = bs1 ? ((addr_lo_reg == 8'h00) ? CAL_BYTE : pnv_pkg::ERASED_BYTE) :
    (addr_lo_reg == 8'h00) ? SIG_0 : (addr_lo_reg == 8'h01) ? SIG_1 :
    (addr_lo_reg == 8'h02) ? SIG_2 : pnv_pkg::ERASED_BYTE;
  wire logic [7:0] fuse_rd = ({bs2, bs1} == 2'h0) ? fuse_low_reg :
    ({bs2, bs1} == 2'h3) ? fuse_high_reg : ({bs2, bs1} == 2'h2) ? fuse_ext_reg : lock_reg;
  wire logic [7:0] rd_mux =
    (cmd_reg == pnv_pkg::CMD_RD_FLASH) ? (bs1 ? flash_rd[15:8] : flash_rd[7:0]) :
    (cmd_reg == pnv_pkg::CMD_RD_EE) ? ee_mem[ee_addr] :
    (cmd_reg == pnv_pkg::CMD_RD_SIG) ? sig_rd :
    (cmd_reg == pnv_pkg::CMD_RD_FUSE) ? fuse_rd : pnv_pkg::ERASED_BYTE;

  assign LINK.dev_dat = dout_reg;
  assign LINK.dev_dat_oe_n = LINK.read_enable_n;
  assign LINK.done_flag = done_reg;
  assign FUSE_LOW_O = fuse_low_reg;
  assign FUSE_HIGH_O = fuse_high_reg;
  assign FUSE_EXT_O = fuse_ext_reg;
  assign LOCK_O = lock_reg;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cmd_reg <= pnv_pkg::CMD_NOP;
      addr_lo_reg <= 8'h00;
      addr_hi_reg <= 8'h00;
      data_lo_reg <= 8'hFF;
      data_hi_reg <= 8'hFF;
      load_prev_reg <= 1'b0;
      latch_prev_reg <= 1'b0;
      wr_prev_reg <= 1'b1;
      dout_reg <= pnv_pkg::ERASED_BYTE;
      ee_mask_reg <= '0;
    end else begin
      load_prev_reg <= LINK.load_pulse_pin;
      latch_prev_reg <= LINK.page_latch_strobe;
      wr_prev_reg <= LINK.write_strobe_n;
      dout_reg <= rd_mux;
      if (load_rise) begin
        case (act)
          pnv_pkg::ACT_ADDR: begin
            if (bs1) begin
              addr_hi_reg <= bus;
            end else begin
              addr_lo_reg <= bus;
            end
          end
          pnv_pkg::ACT_DATA: begin
            if (bs1) begin
              data_hi_reg <= bus;
            end else begin
              data_lo_reg <= bus;
            end
          end
          pnv_pkg::ACT_CMD: cmd_reg <= bus;
          default: ;
        endcase
      end
      // A latch in the clearing cycle still marks its byte.
      if (load_nop || go_ee) begin
        ee_mask_reg <= '0;
      end
      if (latch_rise && is_ee) begin
        ee_mask_reg[ee_word] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Self-timed write sequencer
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg <= ST_IDLE;
      tmr_reg <= '0;
      done_reg <= 1'b1;
      fuse_low_reg <= pnv_pkg::FUSE_LOW_RST;
      fuse_high_reg <= pnv_pkg::FUSE_HIGH_RST;
      fuse_ext_reg <= pnv_pkg::FUSE_EXT_RST;
      lock_reg <= pnv_pkg::LOCK_RST;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (go_any) begin
            state_reg <= ST_BUSY;
            tmr_reg <= tmr_start;
            done_reg <= 1'b0;
          end
        end
        ST_BUSY: begin
          if (tmr_reg == '0) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b1;
          end else begin
            tmr_reg <= tmr_reg - 1'b1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (go_fl) fuse_low_reg <= data_lo_reg;
      if (go_fh) fuse_high_reg <= data_lo_reg;
      if (go_fe) fuse_ext_reg <= data_lo_reg;
      if (go_erase) begin
        lock_reg <= pnv_pkg::LOCK_RST;
      end else if (go_lock) begin
        lock_reg <= lock_reg & data_lo_reg;
      end
    end
  end

  // ****************************************
  // Memory arrays and page buffers
  // ****************************************
  always_ff @(posedge SYS_CLK_I) begin
    if (load_nop) begin
      for (int i = 0; i < pnv_pkg::FLASH_PAGE_WORDS; i++) begin
        flash_buf[i] <= {pnv_pkg::ERASED_BYTE, pnv_pkg::ERASED_BYTE};
      end
    end else if (latch_rise && bs1 && is_flash) begin
      flash_buf[flash_word] <= {data_hi_reg, data_lo_reg};
    end
    if (latch_rise && is_ee) begin
      ee_buf[ee_word] <= data_lo_reg;
    end
    if (go_flash) begin
      for (int i = 0; i < pnv_pkg::FLASH_PAGE_WORDS; i++) begin
        flash_mem[{flash_page, pnv_pkg::FLASH_PAGE_W'(i)}] <= flash_buf[i];
      end
    end
    if (go_ee) begin
      for (int i = 0; i < pnv_pkg::EE_PAGE_BYTES; i++) begin
        if (ee_mask_reg[i]) begin
          ee_mem[{ee_page, pnv_pkg::EE_PAGE_W'(i)}] <= ee_buf[i];
        end
      end
    end
    if (go_erase) begin
      for (int i = 0; i < pnv_pkg::FLASH_WORDS; i++) begin
        flash_mem[i] <= {pnv_pkg::ERASED_BYTE, pnv_pkg::ERASED_BYTE};
      end
      for (int i = 0; i < pnv_pkg::EE_BYTES; i++) begin
        ee_mem[i] <= pnv_pkg::ERASED_BYTE;
      end
    end
  end

endmodule // pnv_device

// ---- rtl/pnv_host.sv ----
`timescale 1ns/1ps
module pnv_host (
  input wire logic SYS_CLK_I, // System clock
  input wire logic RST_N_I, // Asynchronous reset, active low
  input wire logic [7:0] WB_ADR_I, // Byte address
  input wire logic [31:0] WB_DAT_I, // Write data
  output logic [31:0] WB_DAT_O, // Read data
  input wire logic WB_WE_I, // Write enable
  input wire logic [3:0] WB_SEL_I, // Byte lane select
  input wire logic WB_CYC_I, // Cycle
  input wire logic WB_STB_I, // Strobe
  output logic WB_ACK_O, // Acknowledge
  pnv_link_if.host LINK // Programming pins
);

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0] pins_reg;
  logic [7:0] dout_reg;
  logic [7:0] din_reg;
  logic [2:0] stb_reg;
  logic [15:0] pulse_cnt_reg;
  logic ack_reg;
  logic [31:0] rdat_reg;

  wire logic req = WB_CYC_I & WB_STB_I;
  wire logic wr_now = req & ack_reg & WB_WE_I & WB_SEL_I[0];
  wire logic pulse_busy = stb_reg != 3'h0;
  wire logic wr_pins = wr_now & (WB_ADR_I == pnv_pkg::REG_PINS);
  wire logic wr_dout = wr_now & (WB_ADR_I == pnv_pkg::REG_DOUT);
  wire logic wr_stb = wr_now & (WB_ADR_I == pnv_pkg::REG_STROBE) & ~pulse_busy;
  // A write strobe while the device reports busy is dropped.
  wire logic [2:0] stb_new = {WB_DAT_I[pnv_pkg::STB_WRITE] & LINK.done_flag,
    WB_DAT_I[pnv_pkg::STB_LATCH], WB_DAT_I[pnv_pkg::STB_LOAD]};
  wire logic [31:0] rd_mux =
    (WB_ADR_I == pnv_pkg::REG_PINS) ? {27'h0, pins_reg} :
    (WB_ADR_I == pnv_pkg::REG_DOUT) ? {24'h0, dout_reg} :
    (WB_ADR_I == pnv_pkg::REG_STATUS) ? {30'h0, pulse_busy, LINK.done_flag} :
    (WB_ADR_I == pnv_pkg::REG_DIN) ? {24'h0, din_reg} : 32'h0;

  assign WB_ACK_O = ack_reg;
  assign WB_DAT_O = rdat_reg;
  assign LINK.action_sel_lo = pins_reg[pnv_pkg::PIN_ACT_LO];
  assign LINK.action_sel_hi = pins_reg[pnv_pkg::PIN_ACT_HI];
  assign LINK.byte_select_first = pins_reg[pnv_pkg::PIN_BS1];
  assign LINK.byte_select_second = pins_reg[pnv_pkg::PIN_BS2];
  assign LINK.read_enable_n = pins_reg[pnv_pkg::PIN_RD_N];
  assign LINK.load_pulse_pin = stb_reg[pnv_pkg::STB_LOAD];
  assign LINK.page_latch_strobe = stb_reg[pnv_pkg::STB_LATCH];
  assign LINK.write_strobe_n = ~stb_reg[pnv_pkg::STB_WRITE];
  assign LINK.host_dat = dout_reg;
  assign LINK.host_dat_oe_n = ~pins_reg[pnv_pkg::PIN_RD_N];

  // ****************************************
  // Bus slave and pin sequencing
  // ****************************************
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
      pins_reg <= pnv_pkg::PINS_RST;
      dout_reg <= 8'h00;
      din_reg <= 8'h00;
      stb_reg <= 3'h0;
      pulse_cnt_reg <= 16'h0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (req && !ack_reg) rdat_reg <= rd_mux;
      din_reg <= LINK.data_bus;
      if (wr_pins) pins_reg <= WB_DAT_I[4:0];
      if (wr_dout) dout_reg <= WB_DAT_I[7:0];
      if (wr_stb) begin
        stb_reg <= stb_new;
        pulse_cnt_reg <= 16'(pnv_pkg::PULSE_CYC - 1);
      end else if (pulse_busy) begin
        if (pulse_cnt_reg == 16'h0) begin
          stb_reg <= 3'h0;
        end else begin
          pulse_cnt_reg <= pulse_cnt_reg - 16'h1;
        end
      end
    end
  end

endmodule // pnv_host

// ---- bench/pnv_monitor.sv ----
`timescale 1ns/1ps
// ****************
// Link checker.
// ****************
module pnv_monitor #(
  parameter int unsigned BUSY_CYC = 200 // Device write time in cycles
) (
  input wire logic SYS_CLK_I, // Clock
  input wire logic RST_N_I, // Reset, active low
  input wire logic action_sel_hi, // Action select high
  input wire logic action_sel_lo, // Action select low
  input wire logic byte_select_first, // First byte select
  input wire logic byte_select_second, // Second byte select
  input wire logic page_latch_strobe, // Latch strobe
  input wire logic load_pulse_pin, // Load strobe
  input wire logic write_strobe_n, // Write strobe
  input wire logic read_enable_n, // Read enable
  input wire logic done_flag, // Ready flag
  input wire logic host_dat_oe_n, // Host drive enable
  input wire logic dev_dat_oe_n // Device drive enable
);
  logic [7:0] ld_cnt;
  logic [7:0] lt_cnt;
  logic [15:0] bsy_cnt;
  wire logic [3:0] sels = {action_sel_hi, action_sel_lo, byte_select_first, byte_select_second};

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ld_cnt <= 8'h00;
      lt_cnt <= 8'h00;
      bsy_cnt <= 16'h0000;
    end else begin
      ld_cnt <= load_pulse_pin ? ld_cnt + 8'h01 : 8'h00;
      lt_cnt <= page_latch_strobe ? lt_cnt + 8'h01 : 8'h00;
      bsy_cnt <= done_flag ? 16'h0000 : bsy_cnt + 16'h0001;
    end
  end

  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_busy_start;
    done_flag ##1 !done_flag;
  endsequence

  chk_dev_oe: assert property (dev_dat_oe_n == read_enable_n)
    else $error("device bus enable differs from read enable");
  chk_host_oe: assert property (host_dat_oe_n == !read_enable_n)
    else $error("host drives while device reads");
  chk_busy_cause: assert property (s_busy_start |-> !$past(write_strobe_n))
    else $error("busy began without a write strobe");
  chk_busy_len: assert property ($rose(done_flag) |->
    bsy_cnt >= BUSY_CYC && bsy_cnt <= BUSY_CYC + 2)
    else $error("busy time wrong");
  chk_no_wr_busy: assert property (!done_flag |-> !$fell(write_strobe_n))
    else $error("write strobe while busy");
  chk_load_width: assert property ($fell(load_pulse_pin) |-> ld_cnt == pnv_pkg::PULSE_CYC)
    else $error("load pulse width wrong");
  chk_latch_width: assert property ($fell(page_latch_strobe) |-> lt_cnt == pnv_pkg::PULSE_CYC)
    else $error("latch pulse width wrong");
  chk_sel_stable: assert property (load_pulse_pin && $past(load_pulse_pin) |-> $stable(sels))
    else $error("selects moved during load pulse");
endmodule // pnv_monitor

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic clk;
  logic rst_n;
  logic [7:0] adr;
  logic [31:0] dat_w;
  logic [31:0] dat_r;
  logic we;
  logic [3:0] sel;
  logic [3:0] lane = 4'h1;
  logic cyc;
  logic ack;
  logic [7:0] fuse_lo;
  logic [7:0] fuse_hi;
  logic [7:0] fuse_ext;
  logic [7:0] lock_b;
  logic [7:0] q;
  logic [7:0] k;
  logic [7:0] sig [3] = '{8'h5A, 8'h3C, 8'h21};
  int failures;
  int compares;
  int cycles;
  pnv_link_if link();
  // Signature and calibration values are arbitrary.
  pnv_device #(.WR_FLASH_CYC(200), .WR_EE_CYC(200), .ERASE_CYC(200), .WR_FUSE_CYC(200))
    pnv_device_i (
    .SYS_CLK_I(clk), .RST_N_I(rst_n), .LINK(link), .FUSE_LOW_O(fuse_lo),
    .FUSE_HIGH_O(fuse_hi), .FUSE_EXT_O(fuse_ext), .LOCK_O(lock_b));
  pnv_host pnv_host_i (.SYS_CLK_I(clk), .RST_N_I(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat_w),
    .WB_DAT_O(dat_r), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc), .WB_STB_I(cyc),
    .WB_ACK_O(ack), .LINK(link));
  pnv_monitor #(.BUSY_CYC(200)) pnv_monitor_i (.SYS_CLK_I(clk), .RST_N_I(rst_n),
    .action_sel_hi(link.action_sel_hi), .action_sel_lo(link.action_sel_lo),
    .byte_select_first(link.byte_select_first), .byte_select_second(link.byte_select_second),
    .page_latch_strobe(link.page_latch_strobe), .load_pulse_pin(link.load_pulse_pin),
    .write_strobe_n(link.write_strobe_n), .read_enable_n(link.read_enable_n),
    .done_flag(link.done_flag), .host_dat_oe_n(link.host_dat_oe_n),
    .dev_dat_oe_n(link.dev_dat_oe_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      test_done();
    end
  end

  // ****************
  // Shared tasks.
  // ****************
  task automatic test_done();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= lane;
    dat_w <= {24'h000000, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = dat_r[7:0];
    cyc <= 1'b0;
  endtask

  task automatic status(input int bit_i, input logic lvl);
    do begin
      bus(1'b0, pnv_pkg::REG_STATUS, 8'h00);
    end while (q[bit_i] !== lvl);
  endtask

  task automatic pulse(input logic [7:0] p, input logic [7:0] d, input logic [7:0] s);
    bus(1'b1, pnv_pkg::REG_PINS, p);
    bus(1'b1, pnv_pkg::REG_DOUT, d);
    bus(1'b1, pnv_pkg::REG_STROBE, s);
    status(pnv_pkg::STS_PULSE, 1'b0);
  endtask

  task automatic prog(input logic [7:0] p, input logic busy);
    pulse(p, 8'h00, 8'h04);
    cmp_flag(q[pnv_pkg::STS_DONE], !busy);
    status(pnv_pkg::STS_DONE, 1'b1);
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    bus(1'b1, pnv_pkg::REG_PINS, p);
    bus(1'b0, pnv_pkg::REG_DIN, 8'h00);
    bus(1'b0, pnv_pkg::REG_DIN, 8'h00);
    cmp_byte(q, e);
  endtask

  // ****************
  // Scenarios.
  // ****************
  task automatic t_reset();
    cmp_byte(fuse_lo & fuse_hi & fuse_ext & lock_b, 8'hFF);
    // A write without lane 0 selected must leave the pins alone.
    lane = 4'h0;
    bus(1'b1, pnv_pkg::REG_PINS, 8'h0F);
    lane = 4'h1;
    bus(1'b0, pnv_pkg::REG_PINS, 8'h00);
    cmp_byte(q, 8'h10);
    bus(1'b0, 8'h20, 8'h00);
    cmp_byte(q, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_flash();
    pulse(8'h12, pnv_pkg::CMD_WR_FLASH, 8'h01);
    for (k = 8'h00; k < 8'h02; k++) begin
      pulse(8'h10, 8'h41 + k, 8'h01);
      pulse(8'h11, 8'h30 + k, 8'h01);
      pulse(8'h15, 8'hC0 + k, 8'h01);
      pulse(8'h14, 8'h00, 8'h02);
    end
    pulse(8'h14, 8'h05, 8'h01);
    prog(8'h14, 1'b1);
    pulse(8'h12, pnv_pkg::CMD_NOP, 8'h01);
    prog(8'h10, 1'b0);
    pulse(8'h12, pnv_pkg::CMD_RD_FLASH, 8'h01);
    for (k = 8'h00; k < 8'h02; k++) begin
      pulse(8'h10, 8'h41 + k, 8'h01);
      rd(8'h00, 8'h30 + k);
      rd(8'h04, 8'hC0 + k);
    end
    $display("test flash done");
  endtask

  task automatic t_eeprom();
    pulse(8'h12, pnv_pkg::CMD_WR_EE, 8'h01);
    pulse(8'h14, 8'h01, 8'h01);
    pulse(8'h10, 8'h06, 8'h01);
    pulse(8'h11, 8'h5E, 8'h01);
    pulse(8'h14, 8'h00, 8'h02);
    prog(8'h14, 1'b0);
    prog(8'h10, 1'b1);
    pulse(8'h12, pnv_pkg::CMD_RD_EE, 8'h01);
    rd(8'h00, 8'h5E);
    $display("test eeprom done");
  endtask

  task automatic t_fuse();
    pulse(8'h12, pnv_pkg::CMD_WR_FUSE, 8'h01);
    for (k = 8'h00; k < 8'h03; k++) begin
      pulse(8'h11, 8'hA0 + k, 8'h01);
      prog(8'h10 | {k[5:0], 2'b00}, 1'b1);
    end
    cmp_byte(fuse_lo, 8'hA0);
    cmp_byte(fuse_hi, 8'hA1);
    cmp_byte(fuse_ext, 8'hA2);
    pulse(8'h12, pnv_pkg::CMD_RD_FUSE, 8'h01);
    rd(8'h00, 8'hA0);
    rd(8'h0C, 8'hA1);
    rd(8'h08, 8'hA2);
    $display("test fuse done");
  endtask

  task automatic t_lock();
    pulse(8'h12, pnv_pkg::CMD_WR_LOCK, 8'h01);
    pulse(8'h11, 8'hFE, 8'h01);
    prog(8'h10, 1'b1);
    cmp_byte(lock_b, 8'hFE);
    pulse(8'h11, 8'hFD, 8'h01);
    prog(8'h10, 1'b1);
    cmp_byte(lock_b, 8'hFC);
    pulse(8'h11, 8'hFF, 8'h01);
    prog(8'h10, 1'b0);
    cmp_byte(lock_b, 8'hFC);
    pulse(8'h12, pnv_pkg::CMD_RD_FUSE, 8'h01);
    rd(8'h04, 8'hFC);
    pulse(8'h12, pnv_pkg::CMD_ERASE, 8'h01);
    prog(8'h10, 1'b1);
    cmp_byte(lock_b, 8'hFF);
    $display("test lock done");
  endtask

  task automatic t_sig();
    pulse(8'h12, pnv_pkg::CMD_RD_SIG, 8'h01);
    for (k = 8'h00; k < 8'h03; k++) begin
      pulse(8'h10, k, 8'h01);
      rd(8'h00, sig[k]);
    end
    pulse(8'h10, 8'h00, 8'h01);
    rd(8'h04, 8'h80);
    $display("test signature done");
  endtask

  initial begin
    failures = 0;
    compares = 0;
    cycles = 0;
    rst_n = 1'b0;
    cyc = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    dat_w = 32'h00000000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_flash();
    t_eeprom();
    t_fuse();
    t_lock();
    t_sig();
    test_done();
  end
endmodule // tb
